// *** src/rtc_sram.sv ***
// calendar clock with its registers in the top bytes of a 2k x 8 sram
`timescale 1ns/1ps
// Functional notes
// - clock registers occupy byte addresses 7F8 to 7FF of 2k space
// - clock bytes use the same bus cycles as plain ram bytes
// - all values bcd, hours in 24-hour form
// - days per month and leap years corrected automatically through 2099
// - fields: year 00-99, month 01-12, date 01-31, day 01-07, century 00-39
// - read-hold bit 6 of control freezes visible clock registers while set
// - held registers show captured time; internal counters keep running
// - after read-hold clears, all visible registers refresh together within a second
// - write-hold bit 7 of control halts updates for loading time
// - clearing write-hold copies loaded values into counters and restarts the second divider
// - seconds bit 7 stops oscillator and timekeeping when 1
// - freq-test bit 6 of day toggles seconds lsb at 512 Hz
// - sustained seconds read shows data bit 0 toggling at 512 Hz
// - unassigned clock register bits store host data like ram
// - power-fail deselects device: no access, data pins released
// - read: chip and output enable low, write strobe high, byte driven
// - write while chip enable and write strobe both low
// - battery flag day bit 7 read-only, 1 while battery good
module rtc_sram
  import rtc_sram_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic chip_en_n_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic [ADDR_W-1:0] byte_addr_i,
  input wire logic [DATA_W-1:0] data_pins_i,
  output logic [DATA_W-1:0] data_pins_o,
  output logic data_pins_oe_n_o,
  input wire logic power_fail_level_i,
  input wire logic battery_good_flag_i
);

  // ==================================================================
  // pin synchronisers
  logic [1:0] ce_s_q, oe_s_q, we_s_q, pf_s_q, bf_s_q;
  logic [1:0][ADDR_W-1:0] addr_s_q;
  logic [1:0][DATA_W-1:0] din_s_q;
  always_ff @(posedge clock_i) begin
    ce_s_q <= {ce_s_q[0], chip_en_n_i};
    oe_s_q <= {oe_s_q[0], out_en_n_i};
    we_s_q <= {we_s_q[0], write_en_n_i};
    pf_s_q <= {pf_s_q[0], power_fail_level_i};
    bf_s_q <= {bf_s_q[0], battery_good_flag_i};
    addr_s_q <= {addr_s_q[0], byte_addr_i};
    din_s_q <= {din_s_q[0], data_pins_i};
  end
  logic ce_n, oe_n, we_n, pfail;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din;
  assign ce_n = ce_s_q[1];
  assign oe_n = oe_s_q[1];
  assign we_n = we_s_q[1];
  assign pfail = pf_s_q[1];
  assign addr = addr_s_q[1];
  assign din = din_s_q[1];

  function automatic logic is_clock(input logic [ADDR_W-1:0] a);
    is_clock = (a[ADDR_W-1:CLK_IDX_W] == CLOCK_BASE_HI);
  endfunction

  // bcd increment with wrap to a given floor
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] mx,
                                         input logic [7:0] lo);
    if (v >= mx) begin
      bcd_inc = lo;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // ==================================================================
  // bus decode
  logic wr_act, rd_act, wr_act_q, wr_pulse;
  assign wr_act = !pfail && !ce_n && !we_n;
  assign rd_act = !pfail && !ce_n && !oe_n && we_n;
  assign wr_pulse = wr_act && !wr_act_q;

  // ==================================================================
  // ram array, clock bytes kept separately
  logic [DATA_W-1:0] ram_q [RAM_DEPTH];
  logic [DATA_W-1:0] ram_rd_q;
  always_ff @(posedge clock_i) begin
    if (wr_pulse && !is_clock(addr)) begin
      ram_q[addr] <= din;
    end
    ram_rd_q <= ram_q[addr];
  end

  // ==================================================================
  // time state: internal counters and visible copies
  logic [7:0] c_sec_q, c_min_q, c_hour_q, c_day_q, c_date_q, c_mon_q, c_year_q, c_cent_q;
  logic [7:0] c_sec_d, c_min_d, c_hour_d, c_day_d, c_date_d, c_mon_d, c_year_d, c_cent_d;
  logic [7:0] vis_q [8];
  logic [7:0] vis_d [8];
  logic [31:0] div_q, div_d, tdiv_q, tdiv_d;
  logic test_ph_q, test_ph_d, whold_q, whold_d;
  // test divider follows SEC_COUNT so a shortened second of 1024 cycles or more keeps the 512 Hz ratio
  localparam int TEST_DIV = SEC_COUNT / (2 * TEST_HZ);
  localparam int TEST_HALF = (TEST_DIV > 0) ? TEST_DIV : 1;

  logic osc_stop, freq_test, rhold, whold_now, tick;
  assign osc_stop = vis_q[1][OSC_STOP_BIT];
  assign freq_test = vis_q[4][FREQ_TEST_BIT];
  assign rhold = vis_q[0][READ_HOLD_BIT];
  assign whold_now = vis_q[0][WRITE_HOLD_BIT];
  assign tick = !osc_stop && (div_q == 32'(SEC_COUNT - 1));

  logic [7:0] month_len;
  logic leap;
  always_comb begin
    // year divisible by four; 2100 lies past the valid span
    leap = (c_year_q[4] == 1'b0) ? (c_year_q[1:0] == 2'b00) : (c_year_q[1:0] == 2'b10);
    unique case (c_mon_q)
      FEB: month_len = leap ? DAYS_29 : DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = DAYS_30;
      default: month_len = DAYS_31;
    endcase
  end

  always_comb begin
    c_sec_d = c_sec_q;
    c_min_d = c_min_q;
    c_hour_d = c_hour_q;
    c_day_d = c_day_q;
    c_date_d = c_date_q;
    c_mon_d = c_mon_q;
    c_year_d = c_year_q;
    c_cent_d = c_cent_q;
    whold_d = whold_now;
    div_d = osc_stop ? div_q : (tick ? 32'h0000_0000 : div_q + 32'h0000_0001);
    tdiv_d = (tdiv_q == 32'(TEST_HALF - 1)) ? 32'h0000_0000 : tdiv_q + 32'h0000_0001;
    test_ph_d = test_ph_q;
    if (!osc_stop && tdiv_q == 32'(TEST_HALF - 1)) begin
      test_ph_d = !test_ph_q;
    end
    if (whold_q && !whold_now) begin
      // load counters from what the host wrote
      c_sec_d = {1'b0, vis_q[1][6:0]};
      c_min_d = {1'b0, vis_q[2][6:0]};
      c_hour_d = {2'b00, vis_q[3][5:0]};
      c_day_d = {5'b00000, vis_q[4][2:0]};
      c_date_d = {2'b00, vis_q[5][5:0]};
      c_mon_d = {3'b000, vis_q[6][4:0]};
      c_year_d = vis_q[7];
      c_cent_d = {2'b00, vis_q[0][5:0]};
      div_d = 32'h0000_0000;
    end else if (tick) begin
      c_sec_d = bcd_inc(c_sec_q, SEC_MAX, BCD_ZERO);
      if (c_sec_q >= SEC_MAX) begin
        c_min_d = bcd_inc(c_min_q, MIN_MAX, BCD_ZERO);
        if (c_min_q >= MIN_MAX) begin
          c_hour_d = bcd_inc(c_hour_q, HOUR_MAX, BCD_ZERO);
          if (c_hour_q >= HOUR_MAX) begin
            c_day_d = bcd_inc(c_day_q, DAY_MAX, BCD_ONE);
            c_date_d = bcd_inc(c_date_q, month_len, BCD_ONE);
            if (c_date_q >= month_len) begin
              c_mon_d = bcd_inc(c_mon_q, MONTH_MAX, BCD_ONE);
              if (c_mon_q >= MONTH_MAX) begin
                c_year_d = bcd_inc(c_year_q, YEAR_MAX, BCD_ZERO);
                if (c_year_q >= YEAR_MAX) begin
                  c_cent_d = bcd_inc(c_cent_q, CENT_MAX, BCD_ZERO);
                end
              end
            end
          end
        end
      end
    end
  end

  // visible registers: host writes, periodic refresh when not held
  logic refresh;
  assign refresh = !rhold && !whold_now && !whold_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      vis_d[i] = vis_q[i];
    end
    if (refresh) begin
      // all fields copied in one cycle, every clock, so within one second
      vis_d[0] = {vis_q[0][7:6], c_cent_q[5:0]};
      vis_d[1] = {vis_q[1][7], c_sec_q[6:1], freq_test ? test_ph_q : c_sec_q[0]};
      vis_d[2] = {vis_q[2][7], c_min_q[6:0]};
      vis_d[3] = {vis_q[3][7:6], c_hour_q[5:0]};
      vis_d[4] = {vis_q[4][7:3], c_day_q[2:0]};
      vis_d[5] = {vis_q[5][7:6], c_date_q[5:0]};
      vis_d[6] = {vis_q[6][7:5], c_mon_q[4:0]};
      vis_d[7] = c_year_q;
    end
    if (wr_pulse && is_clock(addr)) begin
      vis_d[addr[CLK_IDX_W-1:0]] = din;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      c_sec_q <= BCD_ZERO;
      c_min_q <= BCD_ZERO;
      c_hour_q <= BCD_ZERO;
      c_day_q <= BCD_ONE;
      c_date_q <= BCD_ONE;
      c_mon_q <= BCD_ONE;
      c_year_q <= BCD_ZERO;
      c_cent_q <= BCD_ZERO;
      div_q <= 32'h0000_0000;
      tdiv_q <= 32'h0000_0000;
      test_ph_q <= 1'b0;
      whold_q <= 1'b0;
      wr_act_q <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        vis_q[i] <= BCD_ZERO;
      end
    end else begin
      c_sec_q <= c_sec_d;
      c_min_q <= c_min_d;
      c_hour_q <= c_hour_d;
      c_day_q <= c_day_d;
      c_date_q <= c_date_d;
      c_mon_q <= c_mon_d;
      c_year_q <= c_year_d;
      c_cent_q <= c_cent_d;
      div_q <= div_d;
      tdiv_q <= tdiv_d;
      test_ph_q <= test_ph_d;
      whold_q <= whold_d;
      wr_act_q <= wr_act;
      for (int i = 0; i < 8; i++) begin
        vis_q[i] <= vis_d[i];
      end
    end
  end

  // ==================================================================
  // read data path
  logic [DATA_W-1:0] rd_byte, dout_d;
  logic oe_n_d;
  always_comb begin
    rd_byte = ram_rd_q;
    if (is_clock(addr)) begin
      rd_byte = vis_q[addr[CLK_IDX_W-1:0]];
      if (addr == WEEKDAY_FLAGS_ADDR) begin
        rd_byte[BATTERY_GOOD_BIT] = bf_s_q[1];
      end
    end
    dout_d = rd_byte;
    oe_n_d = !rd_act;
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      data_pins_o <= 8'h00;
      data_pins_oe_n_o <= 1'b1;
    end else begin
      data_pins_o <= dout_d;
      data_pins_oe_n_o <= oe_n_d;
    end
  end

  // ==================================================================
  // checks
  // a host write may still land in a held register, so it is left out here
  sequence s_hold_set;
    rhold && !whold_now && !wr_pulse;
  endsequence
  chk_pfail_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pfail |=> data_pins_oe_n_o) else $error("driving during power fail");
  chk_read_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_act |=> !data_pins_oe_n_o) else $error("read not driven");
  chk_hold_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_hold_set |=> $stable(vis_q[7])) else $error("held year moved");
  chk_sec_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    c_sec_q <= SEC_MAX || whold_q) else $error("seconds out of range");
  chk_osc_stop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    osc_stop && !whold_q |=> $stable(c_sec_q)) else $error("counting while stopped");
  chk_wh_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    whold_q && !whold_now |=> c_year_q == $past(vis_q[7])) else $error("load missed");
  chk_sec_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tick && !whold_q && c_sec_q == SEC_MAX |=> c_sec_q == BCD_ZERO) else $error("wrap");
  chk_refresh: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    refresh && !wr_pulse |=> vis_q[7] == $past(c_year_q)) else $error("no refresh");
endmodule // rtc_sram

// *** src/rtc_sram_pkg.sv ***
// constants for the bcd calendar clock mapped into byte-wide static ram space
package rtc_sram_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 2048;
  // clock registers, top eight bytes of the space
  localparam logic [10:0] CONTROL_CENTURY_ADDR = 11'h7f8;
  localparam logic [10:0] SECONDS_STOP_ADDR = 11'h7f9;
  localparam logic [10:0] MINUTES_ADDR = 11'h7fa;
  localparam logic [10:0] HOURS_ADDR = 11'h7fb;
  localparam logic [10:0] WEEKDAY_FLAGS_ADDR = 11'h7fc;
  localparam logic [10:0] DAY_OF_MONTH_ADDR = 11'h7fd;
  localparam logic [10:0] MONTH_ADDR = 11'h7fe;
  localparam logic [10:0] YEAR_ADDR = 11'h7ff;
  localparam logic [7:0] CLOCK_BASE_HI = 8'hff;
  localparam int CLK_IDX_W = 3;
  // field positions
  localparam int WRITE_HOLD_BIT = 7;
  localparam int READ_HOLD_BIT = 6;
  localparam int OSC_STOP_BIT = 7;
  localparam int BATTERY_GOOD_BIT = 7;
  localparam int FREQ_TEST_BIT = 6;
  // bcd bounds
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] CENT_MAX = 8'h39;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  // timing
  localparam int CLOCK_HZ = 100_000_000;
  localparam int TICK_HZ = 1;
  localparam int TEST_HZ = 512;
  localparam int SEC_CYCLES = CLOCK_HZ / TICK_HZ;
  localparam int HALF_TEST_CYCLES = CLOCK_HZ / (2 * TEST_HZ);
endpackage

// *** tb/rtc_host_model.sv ***
// host model that drives the byte-wide sram bus of the calendar clock
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic clock_i,
  input wire logic dev_oe_n_i,
  input wire logic [7:0] dev_data_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [10:0] addr_o,
  output logic [7:0] wdata_o,
  output logic drive_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic timeout_o
);
  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = 11'h000;
    wdata_o = 8'h00;
    drive_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
    timeout_o = 1'b0;
  end
  // ==========================================
  // bus cycles
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (dev_oe_n_i !== lvl && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 20) timeout_o = 1'b1;
  endtask
  // address and strobes stay put until the byte has been taken
  task automatic rd(input logic [10:0] a);
    @(negedge clock_i);
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    wait_oe(1'b0);
    @(negedge clock_i);
    rd_data_o = dev_data_i;
    rd_valid_o = 1'b1;
    @(negedge clock_i);
    rd_valid_o = 1'b0;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    wait_oe(1'b1);
  endtask
  // sustained read: two bytes taken on consecutive cycles, address held
  task automatic rd_pair(input logic [10:0] a, output logic [7:0] d0, output logic [7:0] d1);
    @(negedge clock_i);
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    wait_oe(1'b0);
    @(negedge clock_i);
    d0 = dev_data_i;
    @(negedge clock_i);
    d1 = dev_data_i;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    wait_oe(1'b1);
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clock_i);
    ce_n_o = 1'b0;
    we_n_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    drive_o = 1'b1;
    repeat (4) @(negedge clock_i);
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    // data held one cycle past the strobe for hold time
    @(negedge clock_i);
    drive_o = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic try_rd(input logic [10:0] a, output logic answered);
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    answered = 1'b0;
    repeat (10) begin
      @(negedge clock_i);
      if (dev_oe_n_i !== 1'b1) answered = 1'b1;
    end
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
  endtask
endmodule // rtc_host_model

// *** tb/test_rtc_sram.sv ***
// self-checking bench for the sram-mapped calendar clock
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp); end end
module test_rtc_sram;
  import rtc_sram_pkg::*;
  typedef struct {logic [7:0] v; bit ne;} note_t;
  localparam logic [7:0] LD_T [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00};
  localparam logic [7:0] RD_T [8] = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h81, 8'h29, 8'h02, 8'h00};
  logic clock_i = 1'b0;
  logic rst_n_i, pf, bat, ce_n, oe_n, we_n, drive, doe_n, rd_valid, to, answered;
  logic [10:0] addr;
  logic [7:0] wdata, dout, rd_data, ft0, ft1;
  // released bus floats: show the inverse so stale data never passes
  wire logic [7:0] bus = !doe_n ? dout : (drive ? wdata : ~wdata);
  int fails = 0;
  int n_checks = 0;
  note_t q[$];
  note_t n;
  logic [31:0] seed = 32'h0000_a400;
  logic [7:0] ram_d [4];
  logic [10:0] ram_a [4];

  initial forever #5 clock_i = ~clock_i;

  rtc_sram #(.SEC_COUNT(100)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .chip_en_n_i(ce_n),
    .out_en_n_i(oe_n), .write_en_n_i(we_n), .byte_addr_i(addr), .data_pins_i(bus),
    .data_pins_o(dout), .data_pins_oe_n_o(doe_n), .power_fail_level_i(pf),
    .battery_good_flag_i(bat));
  rtc_host_model host (.clock_i(clock_i), .dev_oe_n_i(doe_n), .dev_data_i(bus),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .wdata_o(wdata),
    .drive_o(drive), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .timeout_o(to));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] v, input bit ne);
    q.push_back('{v, ne});
    host.rd(a);
  endtask
  // ==========================================
  // result watcher
  always @(posedge clock_i) begin
    if (rd_valid) begin
      n = q.pop_front();
      `CHK(rd_data === n.v, !n.ne)
    end
    if (to) begin
      fails++;
      stop_test();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    rst_n_i = 1'b0;
    pf = 1'b0;
    bat = 1'b1;
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ram_a[i] = {i[2:0], seed[15:8]};
      ram_d[i] = seed[7:0];
      host.wr(ram_a[i], ram_d[i]);
    end
    for (int i = 0; i < 4; i++) rd(ram_a[i], ram_d[i], 1'b0);
    host.wr(CONTROL_CENTURY_ADDR, 8'ha0);
    for (int i = 0; i < 7; i++) host.wr(SECONDS_STOP_ADDR + 11'(i), LD_T[i]);
    host.wr(CONTROL_CENTURY_ADDR, 8'h20);
    // one tick lands before the hold: 23:59:59 feb 28 of a leap year
    repeat (140) @(negedge clock_i);
    host.wr(CONTROL_CENTURY_ADDR, 8'h60);
    for (int i = 0; i < 8; i++) rd(CONTROL_CENTURY_ADDR + 11'(i), RD_T[i], 1'b0);
    repeat (300) @(negedge clock_i);
    rd(SECONDS_STOP_ADDR, 8'h00, 1'b0);
    host.wr(CONTROL_CENTURY_ADDR, 8'h20);
    repeat (5) @(negedge clock_i);
    rd(SECONDS_STOP_ADDR, 8'h00, 1'b1);
    bat = 1'b0;
    host.wr(WEEKDAY_FLAGS_ADDR, 8'hb8);
    rd(WEEKDAY_FLAGS_ADDR, 8'h39, 1'b0);
    host.wr(11'h7f7, 8'h33);
    pf = 1'b1;
    repeat (3) @(negedge clock_i);
    host.wr(11'h7f7, 8'hcc);
    host.try_rd(11'h7f7, answered);
    `CHK(answered, 1'b0)
    pf = 1'b0;
    repeat (3) @(negedge clock_i);
    rd(11'h7f7, 8'h33, 1'b0);
    host.wr(CONTROL_CENTURY_ADDR, 8'ha0);
    host.wr(SECONDS_STOP_ADDR, 8'h85);
    host.wr(CONTROL_CENTURY_ADDR, 8'h20);
    repeat (300) @(negedge clock_i);
    rd(SECONDS_STOP_ADDR, 8'h85, 1'b0);
    // oscillator back on, frequency test set: seconds lsb must toggle under a held read
    host.wr(SECONDS_STOP_ADDR, 8'h05);
    host.wr(WEEKDAY_FLAGS_ADDR, 8'h40);
    host.rd_pair(SECONDS_STOP_ADDR, ft0, ft1);
    `CHK(ft0[0] ^ ft1[0], 1'b1)
    `CHK(ft0[7], 1'b0)
    repeat (4) @(negedge clock_i);
    stop_test();
  end
endmodule // test_rtc_sram
